// [core/isr_slave_port.sv]
// two-wire slave port giving a host access to internal registers and the FIFO
`timescale 1ns/1ps
`default_nettype none
// Function
// - slave only, never drives the clock
// - clock line is never held low
// - general call ignored, no bus reset
// - device identification query is not answered
// - host keeps rate within 400k or 1M
// - spike filter on both lines, always running
// - lines idle high, data changes clock low
// - data falling while clock high is start
// - data rising while clock high is stop
// - repeated start behaves like start, still busy
// - bytes msb first, each followed by acknowledge
// - transmitter releases, receiver pulls low on acknowledge
// - host nack on read, device releases data
// - first byte after start is address
// - write: address byte, then incrementing data stores
// - FIFO address holds pointer, data pushed
// - read returns registers at incrementing addresses
// - FIFO reads keep the pointer still
module isr_slave_port
#(
    parameter logic [7:0] FIFO_ADDR = isr_pkg::FIFO_ADDR_DEF
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic port_sel,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [1:0] adr_pin,
    input wire logic [1:0] adr_nvm,
    input wire logic adr_from_nvm,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    output logic bus_busy
);
    // link clock domain: reset, pins, configuration
    logic [1:0] lrst_q;
    logic link_rst;
    logic [4:0] cfg1_q;
    logic [4:0] cfg2_q;
    logic sel;
    logic [1:0] adr_lo;
    logic scl_f;
    logic sda_f;
    logic scl_p_q;
    logic sda_p_q;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic adr_pin_hi1_q;
    logic adr_pin_hi_q;

    // link clock domain: engine
    isr_pkg::isr_state_e st_q;
    logic [3:0] cnt_q;
    logic [7:0] shr_q;
    logic rnw_q;
    logic tx_rdy_q;
    logic mack_q;
    logic drv_q;
    logic busy_q;
    logic [7:0] ptr_q;
    logic rx_state;
    logic byte_done;
    logic do_match;
    logic issue_rd;
    logic issue_wr;
    logic set_ptr;

    // link side of the handshake
    logic req_tgl_q;
    logic [7:0] req_addr_q;
    logic [7:0] req_dat_q;
    logic req_wr_q;
    logic pend_q;
    logic [2:0] ack_s_q;
    logic ack_edge;

    // system clock domain
    logic [2:0] req_s_q;
    logic req_edge;
    logic ack_tgl_q;
    logic [7:0] rdat_q;
    logic cap_q;
    logic [1:0] busy_s_q;

    isr_pin_if pins ();

    // link reset: asserted at once, released on the link clock
    always_ff @(posedge link_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lrst_q <= 2'h3;
        end
        else
        begin
            lrst_q <= {lrst_q[0], 1'b0};
        end
    end
    assign link_rst = lrst_q[1];

    // static configuration levels cross with two flops
    always_ff @(posedge link_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            cfg1_q <= 5'h00;
            cfg2_q <= 5'h00;
        end
        else
        begin
            cfg1_q <= {port_sel, adr_from_nvm, adr_nvm, adr_pin[0]};
            cfg2_q <= cfg1_q;
        end
    end
    assign sel = cfg2_q[4];
    // low address bits come from the pins or from the stored value
    assign adr_lo = cfg2_q[3] ? cfg2_q[2:1] : {adr_pin_hi_q, cfg2_q[0]};

    always_ff @(posedge link_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            adr_pin_hi1_q <= 1'b0;
            adr_pin_hi_q <= 1'b0;
        end
        else
        begin
            adr_pin_hi1_q <= adr_pin[1];
            adr_pin_hi_q <= adr_pin_hi1_q;
        end
    end

    // filter always runs; the engine only listens while the port is selected
    assign pins.raw[isr_pkg::PIN_SCL] = scl_i;
    assign pins.raw[isr_pkg::PIN_SDA] = sda_i;
    isr_pin_filt isr_pin_filt_i
    (
        .link_clk(link_clk),
        .link_rst(link_rst),
        .pins(pins)
    );
    assign scl_f = pins.flt[isr_pkg::PIN_SCL];
    assign sda_f = pins.flt[isr_pkg::PIN_SDA];

    always_ff @(posedge link_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    assign rise = scl_f & ~scl_p_q;
    assign fall = ~scl_f & scl_p_q;
    assign start = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign stop = scl_f & scl_p_q & ~sda_p_q & sda_f;

    assign rx_state = (st_q == isr_pkg::ST_DEVA) || (st_q == isr_pkg::ST_REGA) || (st_q == isr_pkg::ST_WDAT);
    assign byte_done = rx_state && fall && (cnt_q == isr_pkg::BIT_LAST);
    // general call and the identification query never match the fixed upper bits
    assign do_match = byte_done && (st_q == isr_pkg::ST_DEVA)
                      && (shr_q[7:1] == {isr_pkg::ADR_UPPER, adr_lo});
    assign issue_rd = (do_match && shr_q[0])
                      || ((st_q == isr_pkg::ST_RACK) && rise && !sda_f);
    assign issue_wr = byte_done && (st_q == isr_pkg::ST_WDAT);
    assign set_ptr = byte_done && (st_q == isr_pkg::ST_REGA);

    // bus engine; a start from any state opens a new frame
    always_ff @(posedge link_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            st_q <= isr_pkg::ST_IDLE;
            cnt_q <= 4'h0;
            shr_q <= 8'h00;
            rnw_q <= 1'b0;
            tx_rdy_q <= 1'b0;
            mack_q <= 1'b0;
            drv_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else if (!sel)
        begin
            st_q <= isr_pkg::ST_IDLE;
            drv_q <= 1'b0;
            busy_q <= 1'b0;
            tx_rdy_q <= 1'b0;
        end
        else if (start)
        begin
            st_q <= isr_pkg::ST_DEVA;
            cnt_q <= 4'h0;
            drv_q <= 1'b0;
            busy_q <= 1'b1;
            tx_rdy_q <= 1'b0;
        end
        else if (stop)
        begin
            st_q <= isr_pkg::ST_IDLE;
            drv_q <= 1'b0;
            busy_q <= 1'b0;
            tx_rdy_q <= 1'b0;
        end
        else
        begin
            if (ack_edge && !req_wr_q)
            begin
                shr_q <= rdat_q;
                tx_rdy_q <= 1'b1;
            end
            case (st_q)
                isr_pkg::ST_DEVA, isr_pkg::ST_REGA, isr_pkg::ST_WDAT:
                begin
                    if (rise && cnt_q != isr_pkg::BIT_LAST)
                    begin
                        shr_q <= {shr_q[6:0], sda_f};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    else if (byte_done)
                    begin
                        if (st_q == isr_pkg::ST_DEVA && !do_match)
                        begin
                            st_q <= isr_pkg::ST_SKIP;
                        end
                        else if (st_q == isr_pkg::ST_DEVA)
                        begin
                            rnw_q <= shr_q[0];
                            drv_q <= 1'b1;
                            st_q <= isr_pkg::ST_DACK;
                        end
                        else
                        begin
                            drv_q <= 1'b1;
                            st_q <= isr_pkg::ST_WACK;
                        end
                    end
                end
                isr_pkg::ST_DACK:
                begin
                    if (fall)
                    begin
                        drv_q <= 1'b0;
                        cnt_q <= 4'h0;
                        st_q <= rnw_q ? isr_pkg::ST_RDAT : isr_pkg::ST_REGA;
                    end
                end
                isr_pkg::ST_WACK:
                begin
                    if (fall)
                    begin
                        drv_q <= 1'b0;
                        cnt_q <= 4'h0;
                        st_q <= isr_pkg::ST_WDAT;
                    end
                end
                isr_pkg::ST_RDAT:
                begin
                    // data only moves while the clock is low
                    if (fall && cnt_q == isr_pkg::BIT_LAST)
                    begin
                        drv_q <= 1'b0;
                        st_q <= isr_pkg::ST_RACK;
                    end
                    else if (fall && tx_rdy_q)
                    begin
                        shr_q <= {shr_q[6:0], 1'b1};
                    end
                    else if (!scl_f && tx_rdy_q)
                    begin
                        drv_q <= ~shr_q[7];
                    end
                    if (rise)
                    begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                isr_pkg::ST_RACK:
                begin
                    if (rise)
                    begin
                        mack_q <= !sda_f;
                        tx_rdy_q <= ack_edge && !req_wr_q;
                    end
                    else if (fall)
                    begin
                        cnt_q <= 4'h0;
                        // a missing acknowledge ends the read; the line stays free
                        st_q <= mack_q ? isr_pkg::ST_RDAT : isr_pkg::ST_SKIP;
                    end
                end
                isr_pkg::ST_SKIP:
                begin
                    drv_q <= 1'b0;
                end
                isr_pkg::ST_IDLE:
                begin
                    drv_q <= 1'b0;
                end
                default:
                begin
                    st_q <= isr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // address pointer; the FIFO location never advances it
    always_ff @(posedge link_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            ptr_q <= 8'h00;
        end
        else if (set_ptr)
        begin
            ptr_q <= shr_q;
        end
        else if ((issue_rd || issue_wr) && ptr_q != FIFO_ADDR)
        begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    // request toggle; address and data stay put until the answer returns
    always_ff @(posedge link_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            req_tgl_q <= 1'b0;
            req_addr_q <= 8'h00;
            req_dat_q <= 8'h00;
            req_wr_q <= 1'b0;
            pend_q <= 1'b0;
        end
        else if ((issue_rd || issue_wr) && !pend_q)
        begin
            req_tgl_q <= ~req_tgl_q;
            req_addr_q <= ptr_q;
            req_dat_q <= shr_q;
            req_wr_q <= issue_wr;
            pend_q <= 1'b1;
        end
        else if (ack_edge)
        begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge link_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            ack_s_q <= 3'h0;
        end
        else
        begin
            ack_s_q <= {ack_s_q[1:0], ack_tgl_q};
        end
    end
    assign ack_edge = ack_s_q[2] ^ ack_s_q[1];

    // open drain: only ever pulls low; the clock pin is input only
    always_ff @(posedge link_clk or posedge link_rst)
    begin
        if (link_rst)
        begin
            sda_o <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            sda_o <= 1'b0;
            sda_oe <= drv_q;
        end
    end

    // system side: strobe the register file once per request
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            req_s_q <= 3'h0;
        end
        else
        begin
            req_s_q <= {req_s_q[1:0], req_tgl_q};
        end
    end
    assign req_edge = req_s_q[2] ^ req_s_q[1];

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_addr <= 8'h00;
            reg_wdata <= 8'h00;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
        end
        else
        begin
            reg_wr <= req_edge && req_wr_q;
            reg_rd <= req_edge && !req_wr_q;
            if (req_edge)
            begin
                reg_addr <= req_addr_q;
                reg_wdata <= req_dat_q;
            end
        end
    end

    // read data is taken with the strobe, acknowledged the cycle after
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cap_q <= 1'b0;
            rdat_q <= 8'h00;
            ack_tgl_q <= 1'b0;
        end
        else
        begin
            cap_q <= reg_wr || reg_rd;
            if (cap_q)
            begin
                ack_tgl_q <= ~ack_tgl_q;
            end
            if (reg_rd)
            begin
                rdat_q <= reg_rdata;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busy_s_q <= 2'h0;
            bus_busy <= 1'b0;
        end
        else
        begin
            busy_s_q <= {busy_s_q[0], busy_q};
            bus_busy <= busy_s_q[1];
        end
    end
endmodule
`default_nettype wire

// [core/isr_pkg.sv]
// shared constants and types of the two-wire slave register port
package isr_pkg;
    // fixed upper part of the 7-bit slave address (01010)
    localparam logic [4:0] ADR_UPPER = 5'h0A;
    // default register address of the data FIFO
    localparam logic [7:0] FIFO_ADDR_DEF = 8'h05;
    // bit index of the acknowledge slot within a byte
    localparam logic [3:0] BIT_LAST = 4'h8;
    // bus rate ceilings in kbit/s
    localparam int FM_MAX_KBPS = 400;
    localparam int FMP_MAX_KBPS = 1000;
    // spike suppression width and sampling period of the link clock
    localparam int SPIKE_NS = 50;
    localparam int LINK_PERIOD_NS = 64;
    // samples a level must persist before it is believed
    localparam int FILT_CYC = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS + 1;
    // pin positions inside the filtered pin vector
    localparam int PIN_SDA = 0;
    localparam int PIN_SCL = 1;
    localparam int PIN_N = 2;
    // bus engine states
    typedef enum logic [3:0]
    {
        ST_IDLE,
        ST_DEVA,
        ST_DACK,
        ST_REGA,
        ST_WDAT,
        ST_WACK,
        ST_RDAT,
        ST_RACK,
        ST_SKIP
    } isr_state_e;
endpackage

// [core/isr_pin_if.sv]
// raw and filtered bus pins between the port core and its input filter
`timescale 1ns/1ps
`default_nettype none
interface isr_pin_if;
    logic [isr_pkg::PIN_N-1:0] raw;
    logic [isr_pkg::PIN_N-1:0] flt;
    modport filt
    (
        input raw,
        output flt
    );
    modport core
    (
        output raw,
        input flt
    );
endinterface
`default_nettype wire

// [core/isr_pin_filt.sv]
// two-flop synchroniser and spike suppressor for the bus pins
`timescale 1ns/1ps
`default_nettype none
module isr_pin_filt
#(
    parameter int WIDTH = isr_pkg::PIN_N,
    parameter int NCYC = isr_pkg::FILT_CYC
)
(
    input wire logic link_clk,
    input wire logic link_rst,
    isr_pin_if.filt pins
);
    localparam int CW = $clog2(NCYC + 1);
    localparam logic [CW-1:0] CNT_END = CW'(NCYC - 1);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_pin
            logic s1_q;
            logic s2_q;
            logic flt_q;
            logic [CW-1:0] cnt_q;
            always_ff @(posedge link_clk or posedge link_rst)
            begin
                if (link_rst)
                begin
                    s1_q <= 1'b1;
                    s2_q <= 1'b1;
                end
                else
                begin
                    s1_q <= pins.raw[g];
                    s2_q <= s1_q;
                end
            end
            // a new level is taken only after it held for NCYC samples
            always_ff @(posedge link_clk or posedge link_rst)
            begin
                if (link_rst)
                begin
                    flt_q <= 1'b1;
                    cnt_q <= '0;
                end
                else if (s2_q == flt_q)
                begin
                    cnt_q <= '0;
                end
                else if (cnt_q == CNT_END)
                begin
                    flt_q <= s2_q;
                    cnt_q <= '0;
                end
                else
                begin
                    cnt_q <= cnt_q + CW'(1);
                end
            end
            assign pins.flt[g] = flt_q;
        end
    endgenerate
endmodule
`default_nettype wire

// [tb/isr_host_model.sv]
// bus master model standing in for the host controller
`timescale 1ns/1ps
`default_nettype none
module isr_host_model
#(
    parameter int H = 40
)
(
    input wire logic clock,
    input wire logic sda_line,
    output var logic scl,
    output var logic sda_rel
);
    // the host owns the clock alone; 40 cycles a phase gives 625 kbit/s
    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clock);
    endtask
    // data moves mid-low phase, sampled at the end of the high phase
    task automatic bit_io(input logic b, output logic r);
        sda_rel <= b;
        w(H / 2);
        scl <= 1'b1;
        w(H);
        r = sda_line;
        scl <= 1'b0;
        w(H / 2);
    endtask
    // same sequence serves start and repeated start
    task automatic start_c;
        sda_rel <= 1'b1;
        w(H / 2);
        scl <= 1'b1;
        w(H);
        sda_rel <= 1'b0;
        w(H);
        scl <= 1'b0;
        w(H / 2);
    endtask
    task automatic stop_c;
        sda_rel <= 1'b0;
        w(H / 2);
        scl <= 1'b1;
        w(H);
        sda_rel <= 1'b1;
        w(H);
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask
endmodule
`default_nettype wire

// [tb/isr_slave_port_asserts.sv]
// concurrent checks on the ports of the two-wire slave register port
`timescale 1ns/1ps
`default_nettype none
module isr_slave_port_asserts
#(
    parameter logic [7:0] FIFO_ADDR = 8'h05
)
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic port_sel,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic bus_busy
);
    logic sda_q, st, have_q, fifo_q;
    logic [7:0] prv_q;
    // raw wire start also ends a pointer run, so a repeated start is covered
    assign st = port_sel && scl_i && sda_q && !sda_i;
    always_ff @(posedge clock or posedge sys_rst)
        if (sys_rst)
            sda_q <= 1'b1;
        else
            sda_q <= sda_i;
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst || st)
        begin
            have_q <= 1'b0;
            fifo_q <= 1'b0;
            prv_q <= 8'h00;
        end
        else if (reg_wr || reg_rd)
        begin
            have_q <= 1'b1;
            fifo_q <= (reg_addr == FIFO_ADDR);
            prv_q <= reg_addr;
        end
    end
    sequence s_start;
        port_sel && scl_i && $fell(sda_i);
    endsequence
    sequence s_stop;
        port_sel && scl_i && $rose(sda_i);
    endsequence
    property p_busy_on;
        @(posedge clock) disable iff (sys_rst) s_start |-> ##[1:40] bus_busy;
    endproperty
    a_busy_on: assert property (p_busy_on) else $error("busy not raised");
    property p_busy_off;
        @(posedge clock) disable iff (sys_rst) s_stop |-> ##[1:40] !bus_busy;
    endproperty
    a_busy_off: assert property (p_busy_off) else $error("busy not dropped");
    property p_drv_low;
        @(posedge link_clk) disable iff (sys_rst) sda_oe |-> !sda_o;
    endproperty
    a_drv_low: assert property (p_drv_low) else $error("data driven high");
    property p_hold;
        @(posedge link_clk) disable iff (sys_rst) scl_i [*8] |-> $stable(sda_oe);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved in clock high");
    property p_unsel;
        @(posedge link_clk) disable iff (sys_rst) !port_sel [*8] |-> !sda_oe;
    endproperty
    a_unsel: assert property (p_unsel) else $error("drive while unselected");
    property p_wr_gap;
        @(posedge clock) disable iff (sys_rst) reg_wr |=> (!reg_wr && !reg_rd) [*8];
    endproperty
    a_wr_gap: assert property (p_wr_gap) else $error("write strobe too close");
    property p_rd_gap;
        @(posedge clock) disable iff (sys_rst) reg_rd |=> (!reg_rd && !reg_wr) [*8];
    endproperty
    a_rd_gap: assert property (p_rd_gap) else $error("read strobe too close");
    property p_fifo;
        @(posedge clock) disable iff (sys_rst) (reg_wr || reg_rd) && fifo_q |-> reg_addr == FIFO_ADDR;
    endproperty
    a_fifo: assert property (p_fifo) else $error("fifo pointer moved");
    property p_incr;
        @(posedge clock) disable iff (sys_rst)
            (reg_wr || reg_rd) && have_q && !fifo_q |-> reg_addr == prv_q + 8'h01;
    endproperty
    a_incr: assert property (p_incr) else $error("pointer not incremented");
endmodule
`default_nettype wire

// [tb/isr_slave_port_tb.sv]
// self-checking bench of the two-wire slave register port
`timescale 1ns/1ps
`default_nettype none
module isr_slave_port_tb;
    localparam logic [7:0] FA = 8'h07;
    logic clock = 1'b0;
    logic link_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic port_sel = 1'b1;
    logic adr_from_nvm = 1'b0;
    logic [1:0] adr_pin = 2'h2;
    logic [1:0] adr_nvm = 2'h1;
    logic [7:0] reg_rdata, reg_addr, reg_wdata;
    logic reg_wr, reg_rd, bus_busy, sda_o, sda_oe, scl, sda_rel, sda_line;
    logic [7:0] mem [256];
    logic [7:0] fq [$];
    logic [7:0] pops = 8'h00;
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    always #10 clock = ~clock;
    always #32 link_clk = ~link_clk;
    // pull-up on the data line, device pulls low only
    assign sda_line = sda_rel & ~(sda_oe & ~sda_o);
    // register file answers within the strobe cycle; a fifo read pops
    always_comb reg_rdata = (reg_addr == FA) ? 8'hA0 + pops : mem[reg_addr];
    always @(posedge clock)
    begin
        if (reg_wr && reg_addr == FA)
            fq.push_back(reg_wdata);
        else if (reg_wr)
            mem[reg_addr] <= reg_wdata;
        if (reg_rd && reg_addr == FA)
            pops <= pops + 8'h01;
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            error_cnt++;
            stop_test();
        end
    end
    isr_slave_port #(.FIFO_ADDR(FA)) isr_slave_port_i (.clock(clock), .sys_rst(sys_rst), .link_clk(link_clk),
        .port_sel(port_sel), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .adr_pin(adr_pin),
        .adr_nvm(adr_nvm), .adr_from_nvm(adr_from_nvm), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_busy(bus_busy));
    isr_host_model #(.H(40)) isr_host_model_i (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [7:0] da(input logic [1:0] lo, input logic rd);
        return {isr_pkg::ADR_UPPER, lo, rd};
    endfunction
    // refused frames still send every byte, so ignoring is tested too
    task automatic wframe(input logic [7:0] dv, ra, input int n, input logic [7:0] b, input logic ok);
        logic a;
        isr_host_model_i.start_c();
        isr_host_model_i.send(dv, a);
        chk("addr ack", ok, a);
        if (ok)
            chk("busy", 1'b1, bus_busy);
        isr_host_model_i.send(ra, a);
        chk("reg ack", ok, a);
        for (int i = 0; i < n; i++)
        begin
            isr_host_model_i.send(b + 8'(i), a);
            chk("data ack", ok, a);
        end
        isr_host_model_i.stop_c();
        chk("busy end", 1'b0, bus_busy);
        chk("idle", 1'b1, sda_line);
    endtask
    task automatic rframe(input logic [7:0] ra, input int n, input logic [7:0] b, input logic sr);
        logic a;
        logic [7:0] d;
        isr_host_model_i.start_c();
        isr_host_model_i.send(da(adr_pin, 1'b0), a);
        isr_host_model_i.send(ra, a);
        if (!sr)
            isr_host_model_i.stop_c();
        isr_host_model_i.start_c();
        isr_host_model_i.send(da(adr_pin, 1'b1), a);
        chk("read ack", 1'b1, a);
        chk("busy", 1'b1, bus_busy);
        for (int i = 0; i < n; i++)
        begin
            isr_host_model_i.recv(i == n - 1, d);
            chk("read data", b + 8'(i), d);
        end
        isr_host_model_i.stop_c();
        chk("released", 1'b1, sda_line);
    endtask
    task automatic t_regs;
        wframe(da(2'h2, 1'b0), 8'h10, 3, 8'h30, 1'b1);
        for (int i = 0; i < 3; i++)
            chk("reg store", 8'h30 + 8'(i), mem[8'h10 + i]);
        chk("reg beyond", ~8'h13, mem[8'h13]);
        rframe(8'h10, 3, 8'h30, 1'b0);
    endtask
    task automatic t_fifo;
        wframe(da(2'h2, 1'b0), FA, 3, 8'h50, 1'b1);
        chk("fifo count", 8'h03, 8'(fq.size()));
        for (int i = 0; i < 3; i++)
            chk("fifo data", 8'h50 + 8'(i), fq[i]);
        chk("after fifo", ~(FA + 8'h01), mem[FA + 8'h01]);
        rframe(FA, 3, 8'hA0, 1'b1);
    endtask
    task automatic t_refuse;
        wframe(8'h00, 8'h20, 1, 8'h77, 1'b0);
        wframe(8'hF8, 8'h20, 1, 8'h77, 1'b0);
        wframe(da(2'h1, 1'b0), 8'h20, 1, 8'h77, 1'b0);
        chk("no store", ~8'h20, mem[8'h20]);
    endtask
    task automatic t_nvm;
        adr_from_nvm <= 1'b1;
        wframe(da(2'h1, 1'b0), 8'h40, 1, 8'h66, 1'b1);
        wframe(da(2'h2, 1'b0), 8'h41, 1, 8'h67, 1'b0);
        chk("nvm store", 8'h66, mem[8'h40]);
        chk("pin refused", ~8'h41, mem[8'h41]);
        adr_from_nvm <= 1'b0;
    endtask
    task automatic t_unsel;
        port_sel <= 1'b0;
        wframe(da(2'h2, 1'b0), 8'h42, 1, 8'h68, 1'b0);
        chk("unsel store", ~8'h42, mem[8'h42]);
        port_sel <= 1'b1;
    endtask
    initial
    begin
        foreach (mem[i])
            mem[i] = ~8'(i);
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (50) @(posedge clock);
        t_regs();
        t_fifo();
        t_refuse();
        t_nvm();
        t_unsel();
        stop_test();
    end
endmodule
bind isr_slave_port isr_slave_port_asserts #(.FIFO_ADDR(FIFO_ADDR)) isr_slave_port_asserts_i (.clock(clock),
    .sys_rst(sys_rst), .link_clk(link_clk), .port_sel(port_sel), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .bus_busy(bus_busy));
`default_nettype wire
